// [hw/rfs_params.svh]
`ifndef RFS_PARAMS_SVH
`define RFS_PARAMS_SVH
`define RFS_OFF_INSTR      8'h00
`define RFS_OFF_ACC        8'h04
`define RFS_OFF_STATUS     8'h08
`define RFS_OFF_BANK       8'h0C
`define RFS_OFF_INDEX      8'h10
`define RFS_OFF_CONFIG     8'h14
`define RFS_OFF_MEM_ADDR   8'h18
`define RFS_OFF_MEM_DATA   8'h1C
`define RFS_OFF_POWER      8'h20
`define RFS_OFF_WDOG       8'h24
`define RFS_FLAG_C         0
`define RFS_FLAG_DC        1
`define RFS_FLAG_Z         2
`define RFS_FLAG_OV        3
`define RFS_FLAG_N         4
`define RFS_DEST_BIT       9
`define RFS_ACCESS_BIT     8
`define RFS_POWER_PD       0
`define RFS_POWER_TO       1
`define RFS_POWER_SLEEP    2
`define RFS_INSTR_BUSY     16
`define RFS_INDEXED_MAX    8'h5F
`define RFS_ACCESS_SPLIT   8'h60
`define RFS_HIGH_BANK      4'hF
`define RFS_FILL_VALUE     8'hFF
`define RFS_SLEEP_WORD     16'h0003
`define RFS_OPC_ROTATE     6'h10
`define RFS_OPC_SUBB       6'h15
`define RFS_OPC_SUB        6'h17
`define RFS_OPC_FILL       7'h34
`define RFS_OPC_SUBL       8'h08
`define RFS_RST_PD         1'h1
`define RFS_RST_TO         1'h1
`define RFS_RESP_OKAY      2'h0
`define RFS_RESP_SLVERR    2'h2
`endif

// [hw/rfs_pkg.sv]
package rfs_pkg;
	typedef enum logic [2:0] {PH_IDLE, PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} rfs_phase_t;
	typedef enum logic [2:0] {OP_NONE, OP_ROTATE, OP_FILL, OP_SLEEP, OP_SUBB, OP_SUBL, OP_SUB} rfs_op_t;
endpackage

// [hw/rfs_core.sv]
`include "rfs_params.svh"
// How it works
// - Rotate right plain moves bit 0 to bit 7, touches only N and Z.
// - Destination bit 0 writes the accumulator, 1 writes the register.
// - Access bit 0 uses access bank; 1 uses bank select register.
// - Access 0, extended set on, operand up to 95: indexed literal offset address.
// - Fill ones writes FFh to the register, flags untouched.
// - Sleep clears sleep entry flag and sets watchdog expiry flag.
// - Sleep clears watchdog count and its postscaler.
// - Sleep mode with oscillator halted is entered in phase four.
// - A watchdog wake-up clears the watchdog expiry flag.
// - Subtract with borrow: accumulator minus register minus inverted carry.
// - Literal minus accumulator, result into the accumulator.
// - Register minus accumulator, result to selected destination.
// - Every subtract updates N, OV, C, DC and Z.
module rfs_core (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [7:0]          awaddr,
	input  wire logic                awvalid,
	output logic                     awready,
	input  wire logic [31:0]         wdata,
	input  wire logic [3:0]          wstrb,
	input  wire logic                wvalid,
	output logic                     wready,
	output logic [1:0]               bresp,
	output logic                     bvalid,
	input  wire logic                bready,
	input  wire logic [7:0]          araddr,
	input  wire logic                arvalid,
	output logic                     arready,
	output logic [31:0]              rdata,
	output logic [1:0]               rresp,
	output logic                     rvalid,
	input  wire logic                rready,
	output logic                     sleep_mode,
	output rfs_pkg::rfs_phase_t      phase
);
	import rfs_pkg::*;

	logic [7:0]  mem [0:4095];
	logic [15:0] instr;
	rfs_op_t     op;
	logic [11:0] addr_q;
	logic [7:0]  operand;
	logic [7:0]  result;
	logic [4:0]  flags_q;
	logic [7:0]  acc;
	logic [4:0]  status;
	logic [3:0]  bank_select_register;
	logic [11:0] fsr2;
	logic        ext_en;
	logic [11:0] mem_addr;
	logic        pd;
	logic        to;
	logic [7:0]  wdt_count;
	logic [7:0]  wdt_post;
	logic        aw_hold;
	logic        w_hold;
	logic [7:0]  waddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        wr_fire;
	logic        wr_ok;
	logic [31:0] rd_data;
	logic        rd_ok;
	logic        start;
	logic        dest_f;
	logic        writes_acc;
	logic        writes_mem;
	logic        is_sub;
	logic [7:0]  alu_a;
	logic [7:0]  alu_b;
	logic        alu_cin;
	logic [8:0]  sum9;
	logic [4:0]  sum5;
	logic [7:0]  next_result;
	logic [4:0]  next_flags;

	function automatic logic [11:0] eff_addr(input logic [7:0] f, input logic a,
			input logic ext, input logic [3:0] bank, input logic [11:0] base);
		if (!a && ext && f <= `RFS_INDEXED_MAX) begin
			eff_addr = base + {4'h0, f};
		end else if (!a) begin
			eff_addr = (f < `RFS_ACCESS_SPLIT) ? {4'h0, f} : {`RFS_HIGH_BANK, f};
		end else begin
			eff_addr = {bank, f};
		end
	endfunction

	function automatic rfs_op_t decode_op(input logic [15:0] w);
		if (w == `RFS_SLEEP_WORD) decode_op = OP_SLEEP;
		else if (w[15:10] == `RFS_OPC_ROTATE) decode_op = OP_ROTATE;
		else if (w[15:10] == `RFS_OPC_SUBB) decode_op = OP_SUBB;
		else if (w[15:10] == `RFS_OPC_SUB) decode_op = OP_SUB;
		else if (w[15:9] == `RFS_OPC_FILL) decode_op = OP_FILL;
		else if (w[15:8] == `RFS_OPC_SUBL) decode_op = OP_SUBL;
		else decode_op = OP_NONE;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register bus write side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			aw_hold <= 1'b0;
			waddr_q <= 8'h00;
		end else if (awvalid && awready) begin
			awready <= 1'b0;
			aw_hold <= 1'b1;
			waddr_q <= awaddr;
		end else if (wr_fire) begin
			aw_hold <= 1'b0;
		end else if (!aw_hold && !bvalid) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready  <= 1'b0;
			w_hold  <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (wvalid && wready) begin
			wready  <= 1'b0;
			w_hold  <= 1'b1;
			wdata_q <= wdata;
			wstrb_q <= wstrb;
		end else if (wr_fire) begin
			w_hold <= 1'b0;
		end else if (!w_hold && !bvalid) begin
			wready <= 1'b1;
		end
	end

	assign wr_fire = aw_hold && w_hold && !bvalid;
	assign start = wr_fire && wr_ok && waddr_q == `RFS_OFF_INSTR;

	always_comb begin
		case (waddr_q)
			`RFS_OFF_INSTR:    wr_ok = (phase == PH_IDLE) && !sleep_mode;
			`RFS_OFF_ACC, `RFS_OFF_STATUS, `RFS_OFF_BANK, `RFS_OFF_INDEX,
			`RFS_OFF_CONFIG, `RFS_OFF_MEM_ADDR, `RFS_OFF_POWER: wr_ok = 1'b1;
			`RFS_OFF_MEM_DATA: wr_ok = (phase == PH_IDLE);
			default:           wr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `RFS_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp  <= wr_ok ? `RFS_RESP_OKAY : `RFS_RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register bus read side
	always_comb begin
		rd_ok   = 1'b1;
		rd_data = 32'h0000_0000;
		case (araddr)
			`RFS_OFF_INSTR:    rd_data = {15'h0000, phase != PH_IDLE, instr};
			`RFS_OFF_ACC:      rd_data = {24'h00_0000, acc};
			`RFS_OFF_STATUS:   rd_data = {27'h000_0000, status};
			`RFS_OFF_BANK:     rd_data = {28'h000_0000, bank_select_register};
			`RFS_OFF_INDEX:    rd_data = {20'h0_0000, fsr2};
			`RFS_OFF_CONFIG:   rd_data = {31'h0000_0000, ext_en};
			`RFS_OFF_MEM_ADDR: rd_data = {20'h0_0000, mem_addr};
			`RFS_OFF_MEM_DATA: rd_data = {24'h00_0000, mem[mem_addr]};
			`RFS_OFF_POWER:    rd_data = {29'h0000_0000, sleep_mode, to, pd};
			`RFS_OFF_WDOG:     rd_data = {16'h0000, wdt_post, wdt_count};
			default:           rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `RFS_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_data;
			rresp   <= rd_ok ? `RFS_RESP_OKAY : `RFS_RESP_SLVERR;
		end else if (rvalid) begin
			if (rready) rvalid <= 1'b0;
		end else begin
			arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Four phase sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase <= PH_IDLE;
		end else begin
			case (phase)
				PH_IDLE:    if (start) phase <= PH_DECODE;
				PH_DECODE:  phase <= PH_READ;
				PH_READ:    phase <= PH_PROCESS;
				PH_PROCESS: phase <= PH_WRITE;
				PH_WRITE:   phase <= PH_IDLE;
				default:    phase <= PH_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			instr  <= 16'h0000;
			op     <= OP_NONE;
			addr_q <= 12'h000;
		end else if (start) begin
			instr <= wdata_q[15:0];
		end else if (phase == PH_DECODE) begin
			op     <= decode_op(instr);
			addr_q <= eff_addr(instr[7:0], instr[`RFS_ACCESS_BIT], ext_en, bank_select_register, fsr2);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			operand <= 8'h00;
		end else if (phase == PH_READ) begin
			operand <= (op == OP_SUBL) ? instr[7:0] : mem[addr_q];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Data processing
	assign is_sub = (op == OP_SUBB) || (op == OP_SUBL) || (op == OP_SUB);

	always_comb begin
		alu_a   = operand;
		alu_b   = acc;
		alu_cin = 1'b1;
		if (op == OP_SUBB) begin
			alu_a   = acc;
			alu_b   = operand;
			alu_cin = status[`RFS_FLAG_C];
		end
		sum9 = {1'b0, alu_a} + {1'b0, ~alu_b} + {8'h00, alu_cin};
		sum5 = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + {4'h0, alu_cin};
		case (op)
			OP_ROTATE: next_result = {operand[0], operand[7:1]};
			OP_FILL:   next_result = `RFS_FILL_VALUE;
			default:   next_result = sum9[7:0];
		endcase
		next_flags = status;
		if (is_sub) begin
			next_flags[`RFS_FLAG_C]  = sum9[8];
			next_flags[`RFS_FLAG_DC] = sum5[4];
			next_flags[`RFS_FLAG_OV] = (alu_a[7] != alu_b[7]) && (sum9[7] != alu_a[7]);
		end
		if (is_sub || op == OP_ROTATE) begin
			next_flags[`RFS_FLAG_N] = next_result[7];
			next_flags[`RFS_FLAG_Z] = (next_result == 8'h00);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result  <= 8'h00;
			flags_q <= 5'h00;
		end else if (phase == PH_PROCESS) begin
			result  <= next_result;
			flags_q <= next_flags;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Destination write and state registers
	assign dest_f     = instr[`RFS_DEST_BIT];
	assign writes_acc = (op == OP_SUBL) || (!dest_f && (op == OP_ROTATE || op == OP_SUBB ||
		op == OP_SUB));
	assign writes_mem = (op == OP_FILL) || (dest_f && (op == OP_ROTATE || op == OP_SUBB ||
		op == OP_SUB));

	always_ff @(posedge aclk) begin
		if (phase == PH_WRITE && writes_mem) begin
			mem[addr_q] <= result;
		end else if (wr_fire && wr_ok && waddr_q == `RFS_OFF_MEM_DATA && wstrb_q[0]) begin
			mem[mem_addr] <= wdata_q[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc <= 8'h00;
		end else if (phase == PH_WRITE && writes_acc) begin
			acc <= result;
		end else if (wr_fire && waddr_q == `RFS_OFF_ACC) begin
			acc <= 8'(merge({24'h00_0000, acc}, wdata_q, wstrb_q));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status <= 5'h00;
		end else if (phase == PH_WRITE && (is_sub || op == OP_ROTATE)) begin
			status <= flags_q;
		end else if (wr_fire && waddr_q == `RFS_OFF_STATUS) begin
			status <= 5'(merge({27'h000_0000, status}, wdata_q, wstrb_q));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bank_select_register      <= 4'h0;
			fsr2     <= 12'h000;
			ext_en   <= 1'b0;
			mem_addr <= 12'h000;
		end else if (wr_fire) begin
			case (waddr_q)
				`RFS_OFF_BANK:     bank_select_register <= 4'(merge({28'h000_0000, bank_select_register}, wdata_q, wstrb_q));
				`RFS_OFF_INDEX:    fsr2 <= 12'(merge({20'h0_0000, fsr2}, wdata_q, wstrb_q));
				`RFS_OFF_CONFIG:   if (wstrb_q[0]) ext_en <= wdata_q[0];
				`RFS_OFF_MEM_ADDR: mem_addr <= 12'(merge({20'h0_0000, mem_addr}, wdata_q, wstrb_q));
				default:           mem_addr <= mem_addr;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sleep, power flags and watchdog
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleep_mode <= 1'b0;
			pd         <= `RFS_RST_PD;
			to         <= `RFS_RST_TO;
		end else if (phase == PH_WRITE && op == OP_SLEEP) begin
			sleep_mode <= 1'b1;
			pd         <= 1'b0;
			to         <= 1'b1;
		end else if (wr_fire && waddr_q == `RFS_OFF_POWER && wstrb_q[0] && sleep_mode) begin
			if (wdata_q[`RFS_POWER_PD]) sleep_mode <= 1'b0;
			if (wdata_q[`RFS_POWER_PD] && wdata_q[`RFS_POWER_TO]) to <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdt_count <= 8'h00;
			wdt_post  <= 8'h00;
		end else if (phase == PH_WRITE && op == OP_SLEEP) begin
			wdt_count <= 8'h00;
			wdt_post  <= 8'h00;
		end else begin
			wdt_count <= wdt_count + 8'h01;
			if (wdt_count == 8'hFF) wdt_post <= wdt_post + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_four_phase: assert property (start |=> phase == PH_DECODE ##1 phase == PH_READ ##1
		phase == PH_PROCESS ##1 phase == PH_WRITE ##1 phase == PH_IDLE)
		else $error("phase sequence broken");
	a_rotate_value: assert property (phase == PH_PROCESS && op == OP_ROTATE |=>
		result == {$past(operand[0]), $past(operand[7:1])} ##1
		status[`RFS_FLAG_OV] == $past(status[`RFS_FLAG_OV], 2) &&
		status[1:0] == $past(status[1:0], 2))
		else $error("rotate result wrong");
	a_dest_acc: assert property (phase == PH_WRITE && writes_acc && !writes_mem |=>
		acc == $past(result))
		else $error("accumulator not written");
	a_bank_addr: assert property (phase == PH_READ && instr[`RFS_ACCESS_BIT] |->
		addr_q == {bank_select_register, instr[7:0]})
		else $error("bank address wrong");
	a_indexed_addr: assert property (phase == PH_READ && !instr[`RFS_ACCESS_BIT] && ext_en &&
		instr[7:0] <= `RFS_INDEXED_MAX |-> addr_q == fsr2 + {4'h0, instr[7:0]})
		else $error("indexed address wrong");
	a_fill_flags: assert property (phase == PH_WRITE && op == OP_FILL |=>
		mem[$past(addr_q)] == `RFS_FILL_VALUE && $stable(status))
		else $error("fill wrong");
	a_sleep_flags: assert property (phase == PH_WRITE && op == OP_SLEEP |=> !pd && to)
		else $error("sleep flags wrong");
	a_sleep_wdt: assert property (phase == PH_WRITE && op == OP_SLEEP |=>
		wdt_count == 8'h00 && wdt_post == 8'h00)
		else $error("watchdog not cleared");
	a_sleep_entry: assert property (start && wdata_q[15:0] == `RFS_SLEEP_WORD |->
		!sleep_mode [*5] ##1 sleep_mode)
		else $error("sleep entry timing wrong");
	a_wdt_wake: assert property (wr_fire && waddr_q == `RFS_OFF_POWER && sleep_mode &&
		wstrb_q[0] && wdata_q[1:0] == 2'h3 |=> !to && !sleep_mode)
		else $error("watchdog wake flag wrong");
	a_borrow_sub: assert property (phase == PH_PROCESS && op == OP_SUBB |=>
		result == $past(acc) - $past(operand) - {7'h00, !$past(status[`RFS_FLAG_C])})
		else $error("borrow subtract wrong");
	a_literal_sub: assert property (phase == PH_PROCESS && op == OP_SUBL |=>
		result == $past(instr[7:0]) - $past(acc) ##1 acc == $past(result))
		else $error("literal subtract wrong");
	a_reg_sub: assert property (phase == PH_PROCESS && op == OP_SUB |=>
		result == $past(operand) - $past(acc))
		else $error("register subtract wrong");
	a_sub_zero: assert property (phase == PH_WRITE && is_sub |=>
		status[`RFS_FLAG_Z] == ($past(result) == 8'h00) && status[`RFS_FLAG_N] == $past(result[7]))
		else $error("zero or negative flag wrong");
	a_carry_borrow: assert property (phase == PH_PROCESS && op == OP_SUB |=>
		flags_q[`RFS_FLAG_C] == ($past(operand) >= $past(acc)))
		else $error("carry not inverted borrow");

	c_sleep: cover property (phase == PH_WRITE && op == OP_SLEEP);
	c_borrow_neg: cover property (phase == PH_WRITE && op == OP_SUBB && !flags_q[`RFS_FLAG_C]);
	c_indexed: cover property (phase == PH_READ && !instr[`RFS_ACCESS_BIT] && ext_en);
	c_wake: cover property (sleep_mode ##1 !sleep_mode);
endmodule

// [tb/rotate_fill_sleep_subtract_ops_tb.sv]
`include "rfs_params.svh"
module rotate_fill_sleep_subtract_ops_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rfs_pkg::*;
	logic        aclk;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  wstrb = 4'hF;
	logic        wvalid = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready = 1'b0;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready = 1'b0;
	logic        sleep_mode;
	rfs_phase_t  phase;
	int          n_mismatch = 0;
	int          compares = 0;
	int          cyc = 0;
	int          seed = 32'ha7a9;
	logic [2:0]  pp = 3'h0;
	////////////////////////////////////////////////////////////////
	rfs_core dut (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.awaddr     (awaddr),
		.awvalid    (awvalid),
		.awready    (awready),
		.wdata      (wdata),
		.wstrb      (wstrb),
		.wvalid     (wvalid),
		.wready     (wready),
		.bresp      (bresp),
		.bvalid     (bvalid),
		.bready     (bready),
		.araddr     (araddr),
		.arvalid    (arvalid),
		.arready    (arready),
		.rdata      (rdata),
		.rresp      (rresp),
		.rvalid     (rvalid),
		.rready     (rready),
		.sleep_mode (sleep_mode),
		.phase      (phase)
	);
	////////////////////////////////////////////////////////////////
	task automatic close_out;
		if (n_mismatch == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// Write with address and data offered together
	task automatic wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 200);
		if (n >= 200) n_mismatch++;
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 200);
		if (n >= 200) n_mismatch++;
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	// Start an instruction and wait for busy to clear
	task automatic exec(input logic [15:0] w);
		logic [1:0]  rs;
		logic [31:0] v;
		int          n;
		wr(`RFS_OFF_INSTR, {16'h0000, w}, rs);
		chk(rs, `RFS_RESP_OKAY);
		n = 0;
		do begin
			rd(`RFS_OFF_INSTR, v, rs);
			n++;
		end while (v[`RFS_INSTR_BUSY] !== 1'b0 && n < 50);
		if (v[`RFS_INSTR_BUSY] !== 1'b0) n_mismatch++;
	endtask
	// Subtract a - b - !cin, returns {result, N, OV, Z, DC, C}
	function automatic logic [12:0] sub_m(input logic [7:0] a, b, input logic cin);
		logic [7:0] nb;
		logic [8:0] s;
		logic [4:0] h;
		nb = ~b;
		s = a + nb + cin;
		h = a[3:0] + nb[3:0] + cin;
		return {s[7:0], s[7], (a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
	endfunction
	////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_mismatch++;
			close_out();
		end
	end
	// Phase order decode, read, process, write, then idle
	always @(posedge aclk) begin
		if (aresetn && pp != 3'h0)
			chk(32'(phase), pp == 3'h4 ? 32'h0 : 32'(pp + 3'h1));
		pp <= phase;
	end
	initial begin
		int          i;
		logic [31:0] rw, rw2, v;
		logic [7:0]  f, acc, mv, r;
		logic [4:0]  st, es;
		logic [3:0]  bank;
		logic [11:0] base, ad;
		logic        d, a, ext, dst;
		logic [1:0]  rs;
		logic [2:0]  op;
		logic [15:0] w;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`RFS_OFF_POWER, v, rs);
		chk(v & 32'h7, {`RFS_RST_TO, `RFS_RST_PD});
		rd(8'h40, v, rs);
		chk(rs, `RFS_RESP_SLVERR);
		wr(8'h40, 32'h0, rs);
		chk(rs, `RFS_RESP_SLVERR);
		wr(`RFS_OFF_POWER, 32'h3, rs);
		rd(`RFS_OFF_POWER, v, rs);
		chk(v & 32'h7, 32'h3);
		for (i = 0; i < 150; i++) begin
			rw = $random(seed);
			rw2 = $random(seed);
			{d, a, ext} = {rw[0], rw[1], rw[2]};
			op = 3'(rw[6:4] % 3'd5);
			{f, acc, mv} = {rw[15:8], rw[23:16], rw[31:24]};
			{bank, base, st} = {rw2[3:0], rw2[15:4], rw2[20:16]};
			if (i % 8 == 0) f = 8'h5F;
			if (i % 8 == 1) f = 8'h60;
			if (i % 8 == 2) mv = acc;
			if (i % 8 == 3) {mv, acc} = 16'h8001;
			ad = (!a && ext && f <= `RFS_INDEXED_MAX) ? base + 12'(f) :
				a ? {bank, f} : (f < `RFS_ACCESS_SPLIT ? 12'(f) : {`RFS_HIGH_BANK, f});
			case (op)
				3'd0: w = {`RFS_OPC_ROTATE, d, a, f};
				3'd1: w = {`RFS_OPC_FILL, a, f};
				3'd2: w = {`RFS_OPC_SUBB, d, a, f};
				3'd3: w = {`RFS_OPC_SUBL, f};
				default: w = {`RFS_OPC_SUB, d, a, f};
			endcase
			case (op)
				3'd0: {r, es, dst} = {mv[0], mv[7:1], mv[0], st[3], mv[7:1] == 7'h0 && !mv[0], st[1:0], d};
				3'd1: {r, es, dst} = {`RFS_FILL_VALUE, st, 1'b1};
				3'd2: {r, es, dst} = {sub_m(acc, mv, st[0]), d};
				3'd3: {r, es, dst} = {sub_m(f, acc, 1'b1), 1'b0};
				default: {r, es, dst} = {sub_m(mv, acc, 1'b1), d};
			endcase
			wr(`RFS_OFF_CONFIG, {31'h0, ext}, rs);
			wr(`RFS_OFF_BANK, {28'h0, bank}, rs);
			wr(`RFS_OFF_INDEX, {20'h0, base}, rs);
			wr(`RFS_OFF_MEM_ADDR, {20'h0, ad}, rs);
			wr(`RFS_OFF_MEM_DATA, {24'h0, mv}, rs);
			wr(`RFS_OFF_ACC, {24'h0, acc}, rs);
			wr(`RFS_OFF_STATUS, {27'h0, st}, rs);
			exec(w);
			rd(`RFS_OFF_ACC, v, rs);
			chk(v & 32'hFF, dst ? acc : r);
			rd(`RFS_OFF_STATUS, v, rs);
			chk(v & 32'h1F, es);
			rd(`RFS_OFF_MEM_DATA, v, rs);
			chk(v & 32'hFF, dst ? r : mv);
		end
		// Masked lanes and an undecoded word leave the accumulator alone
		wr(`RFS_OFF_ACC, 32'h0000_005A, rs);
		wstrb <= 4'hE;
		wr(`RFS_OFF_ACC, 32'h0000_00A5, rs);
		wstrb <= 4'hF;
		exec(16'hFFFF);
		rd(`RFS_OFF_ACC, v, rs);
		chk(v & 32'hFF, 32'h5A);
		for (i = 0; i < 2; i++) begin
			exec(`RFS_SLEEP_WORD);
			chk(sleep_mode, 1'b1);
			rd(`RFS_OFF_POWER, v, rs);
			chk(v & 32'h7, 32'h6);
			rd(`RFS_OFF_WDOG, v, rs);
			chk(v[15:8], 8'h00);
			chk(v[7:0] < 8'd40, 1'b1);
			wr(`RFS_OFF_INSTR, {16'h0, `RFS_OPC_FILL, 9'h000}, rs);
			chk(rs, `RFS_RESP_SLVERR);
			wr(`RFS_OFF_POWER, i == 0 ? 32'h1 : 32'h3, rs);
			rd(`RFS_OFF_POWER, v, rs);
			chk(v & 32'h7, i == 0 ? 32'h2 : 32'h0);
			chk(sleep_mode, 1'b0);
		end
		close_out();
	end
endmodule
